// *** design/rail_seq_pkg.sv ***
// constants, types and register map of the rail sequencing block
// Overview of operation
// - hold loop tuning word, default 015A0100h
// - turn on after enable and prequel power-good
// - sequenced turn-off on sequel power-down event
// - bit15 prequel enable, 12:8 prequel id
// - bit7 sequel enable, 4:0 sequel id
// - sequencing word resets to 0000h
// - written sequencing word overrides pin strapping
// - bit21 enables voltage broadcast, id 20:16
// - bit13 enables operation broadcast, id 12:8
// - power-fail match: bit5 immediate else sequenced
// - group word resets to zero, reserved zero
// - identifier read returns 16 ASCII bytes
// - overcurrent sets status flag; bits 7:6 = 10
// - retry 000 holds output off until clear
// - retry 111 restarts repeatedly without fault check
// - retry wait is (delay+1) times 35 ms
// - overcurrent response resets to 80h
package rail_seq_pkg;

  // command codes
  localparam logic [7:0] CODE_OPERATION   = 8'h01;
  localparam logic [7:0] CODE_STATUS_IOUT = 8'h7b;
  localparam logic [7:0] CODE_LOOP_CFG    = 8'hdf;
  localparam logic [7:0] CODE_RAIL_ORDER  = 8'he0;
  localparam logic [7:0] CODE_GROUP_CFG   = 8'he2;
  localparam logic [7:0] CODE_IDENT       = 8'he4;
  localparam logic [7:0] CODE_OC_RESP     = 8'he5;

  // reset values
  localparam logic [24:0] LOOP_RST  = 25'h15a0100;
  localparam logic [15:0] ORDER_RST = 16'h0000;
  localparam logic [23:0] GROUP_RST = 24'h000000;
  localparam logic [7:0]  OC_RST    = 8'h80;
  localparam logic [7:0]  OPER_RST  = 8'h80;

  // writable bit masks; reserved bits stay zero, overcurrent response bits 7:6 fixed at 10
  localparam logic [15:0] ORDER_MASK = 16'h9f9f;
  localparam logic [23:0] GROUP_MASK = 24'h3f3f3f;
  localparam logic [1:0]  OC_FIXED   = 2'b10;

  // field positions
  localparam int PRE_EN    = 15;
  localparam int PRE_ID_LO = 8;
  localparam int SEQ_EN    = 7;
  localparam int SEQ_ID_LO = 0;
  localparam int VB_EN     = 21;
  localparam int VB_ID_LO  = 16;
  localparam int OB_EN     = 13;
  localparam int OB_ID_LO  = 8;
  localparam int PF_FAST   = 5;
  localparam int PF_ID_LO  = 0;
  localparam int OC_RETRY_LO = 3;
  localparam int OC_DELAY_LO = 0;
  localparam int OC_FLAG_BIT = 7;
  localparam int OPER_ON_BIT = 7;
  localparam logic [2:0] RETRY_NONE = 3'b000;
  localparam logic [2:0] RETRY_LOOP = 3'b111;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned RETRY_UNIT_MS  = 35;
  localparam int unsigned RETRY_UNIT_CYC =
    RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned OFF_DELAY_CYC  = 16;

  // arbitrary neutral identifier, 16 ASCII characters
  localparam logic [127:0] IDENT_DEFAULT = "RAILSEQ-A0-FW01 ";

  typedef enum logic [2:0] {
    EV_PGOOD,
    EV_PDOWN,
    EV_PFAIL,
    EV_VOUT,
    EV_OPER
  } ev_kind_t;

  typedef struct packed {
    logic        valid;
    ev_kind_t    kind;
    logic [4:0]  id;
    logic [15:0] data;
  } imb_event_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [31:0] wdata;
    logic [3:0]  byteIdx;
  } cmd_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] data;
  } cmd_rsp_t;

endpackage : rail_seq_pkg

// *** design/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and filtered levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] levelOut
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1_q[i]     <= 1'b0;
          s2_q[i]     <= 1'b0;
          s3_q[i]     <= 1'b0;
          levelOut[i] <= 1'b0;
        end
        else
        begin
          s1_q[i] <= pinIn[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // first stage is never looked at, only stages two and three
          if (s2_q[i] == s3_q[i])
            levelOut[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// *** design/rail_sequencing_fault_config.sv ***
// rail sequencing, group broadcast and overcurrent retry controller
`timescale 1ns/1ns
module rail_sequencing_fault_config #(
  parameter int unsigned    RETRY_CYC = rail_seq_pkg::RETRY_UNIT_CYC,
  parameter int unsigned    OFF_CYC   = rail_seq_pkg::OFF_DELAY_CYC,
  parameter logic [127:0]   IDENT     = rail_seq_pkg::IDENT_DEFAULT
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // management command port
  input  wire rail_seq_pkg::cmd_req_t cmdReq,
  input  wire logic                   clearFaults,
  output rail_seq_pkg::cmd_rsp_t      cmdRsp,
  // inter-module bus events, decoded on this clock
  input  wire rail_seq_pkg::imb_event_t imbEvent,
  // pins
  input  wire logic                   enablePin,
  input  wire logic                   ocFaultPin,
  input  wire logic                   biasOkPin,
  input  wire logic [15:0]            strapOrder,
  // power stage control
  output logic                        railOn,
  output logic                        rampingDown,
  output logic [15:0]                 voutTarget,
  output logic [7:0]                  operation,
  output logic [31:0]                 loopCfg,
  output logic [7:0]                  statusIout
);
  import rail_seq_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_PRE,
    ST_ON,
    ST_RAMP,
    ST_FAULT,
    ST_RETRY,
    ST_HOLD  // off after a shutdown until enable drops
  } state_t;

  state_t       state_q;
  state_t       state_d;
  logic [24:0]  loop_q;
  logic [15:0]  order_q;
  logic [15:0]  strap_q;
  logic         strapTaken_q;
  logic         orderWritten_q;
  logic [23:0]  group_q;
  logic [7:0]   oc_q;
  logic         preGood_q;
  logic [31:0]  offCnt_q;
  logic [31:0]  retryCnt_q;
  logic [2:0]   pinsS;

  pin_sync #(
    .W(3)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .pinIn    ({biasOkPin, ocFaultPin, enablePin}),
    .levelOut (pinsS)
  );

  wire enS   = pinsS[0];
  wire ocS   = pinsS[1];
  wire biasS = pinsS[2];

  // command decode
  wire wrEn      = cmdReq.valid && cmdReq.write;
  wire rdEn      = cmdReq.valid && !cmdReq.write;
  wire wrOper    = wrEn && (cmdReq.code == CODE_OPERATION);
  wire wrLoop    = wrEn && (cmdReq.code == CODE_LOOP_CFG);
  wire wrOrder   = wrEn && (cmdReq.code == CODE_RAIL_ORDER);
  wire wrGroup   = wrEn && (cmdReq.code == CODE_GROUP_CFG);
  wire wrOc      = wrEn && (cmdReq.code == CODE_OC_RESP);
  wire wrKnown   = wrOper || wrLoop || wrOrder || wrGroup || wrOc;

  // identifier byte 0 is the first character, at the top of the string
  wire [127:0] identShift = IDENT >> {~cmdReq.byteIdx, 3'b000};
  wire [7:0]   identByte  = identShift[7:0];

  wire [15:0] orderEff = orderWritten_q ? order_q : strap_q;

  logic [31:0] rdData;
  logic        rdKnown;
  always_comb
  begin
    rdKnown = 1'b1;
    unique case (cmdReq.code)
      CODE_OPERATION:   rdData = {24'h000000, operation};
      CODE_STATUS_IOUT: rdData = {24'h000000, statusIout};
      CODE_LOOP_CFG:    rdData = {7'h00, loop_q};
      CODE_RAIL_ORDER:  rdData = {16'h0000, order_q};
      CODE_GROUP_CFG:   rdData = {8'h00, group_q};
      CODE_IDENT:       rdData = {24'h000000, identByte};
      CODE_OC_RESP:     rdData = {24'h000000, oc_q};
      default:
      begin
        rdData  = 32'h00000000;
        rdKnown = 1'b0;
      end
    endcase
  end

  // inter-module event matching
  wire evPg = imbEvent.valid && (imbEvent.kind == EV_PGOOD);
  wire evPd = imbEvent.valid && (imbEvent.kind == EV_PDOWN);
  wire evPf = imbEvent.valid && (imbEvent.kind == EV_PFAIL);
  wire evVb = imbEvent.valid && (imbEvent.kind == EV_VOUT);
  wire evOb = imbEvent.valid && (imbEvent.kind == EV_OPER);
  wire preMatch = evPg && orderEff[PRE_EN] &&
                  (imbEvent.id == orderEff[PRE_ID_LO +: 5]);
  wire seqMatch = evPd && orderEff[SEQ_EN] &&
                  (imbEvent.id == orderEff[SEQ_ID_LO +: 5]);
  wire pfMatch  = evPf && (imbEvent.id == group_q[PF_ID_LO +: 5]);
  wire vbMatch  = evVb && group_q[VB_EN] &&
                  (imbEvent.id == group_q[VB_ID_LO +: 5]);
  wire obMatch  = evOb && group_q[OB_EN] &&
                  (imbEvent.id == group_q[OB_ID_LO +: 5]);
  wire pfFast   = pfMatch && group_q[PF_FAST];

  wire enableOk  = enS && operation[OPER_ON_BIT];
  wire [2:0] retryMode = oc_q[OC_RETRY_LO +: 3];
  wire [2:0] retryDly  = oc_q[OC_DELAY_LO +: 3];
  wire [31:0] retryLoad =
    32'((32'({29'd0, retryDly}) + 32'd1) * RETRY_CYC);
  wire enterRamp  = (state_d == ST_RAMP) && (state_q != ST_RAMP);
  wire enterRetry = (state_d == ST_RETRY) && (state_q != ST_RETRY);
  wire ocTrip     = (state_q == ST_ON) && ocS;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF:
        if (enableOk && biasS)
          state_d = (orderEff[PRE_EN] && !preGood_q) ? ST_WAIT_PRE
                                                     : ST_ON;
      ST_WAIT_PRE:
        if (!enableOk || !biasS)
          state_d = ST_OFF;
        else if (preGood_q || preMatch)
          state_d = ST_ON;
      ST_ON:
        if (!biasS || pfFast)
          state_d = biasS ? ST_HOLD : ST_OFF;
        else if (ocS)
          state_d = (retryMode == RETRY_LOOP) ? ST_RETRY
                                              : ST_FAULT;
        else if (pfMatch || seqMatch || !enableOk)
          state_d = ST_RAMP;
      ST_RAMP:
        if (!biasS || offCnt_q == 32'd0)
          state_d = biasS ? ST_HOLD : ST_OFF;
      ST_FAULT:
        // unused retry codes behave as no retry
        if (!biasS || clearFaults)
          state_d = ST_OFF;
      ST_RETRY:
        if (!biasS || !enableOk || pfMatch)
          state_d = (biasS && enableOk) ? ST_HOLD : ST_OFF;
        else if (retryCnt_q <= 32'd1)
          state_d = ST_ON;
      ST_HOLD:
        if (!biasS || !enableOk)
          state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= ST_OFF;
      railOn      <= 1'b0;
      rampingDown <= 1'b0;
      offCnt_q    <= 32'd0;
      retryCnt_q  <= 32'd0;
      preGood_q   <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      railOn      <= (state_d == ST_ON) || (state_d == ST_RAMP);
      rampingDown <= (state_d == ST_RAMP);
      offCnt_q    <= enterRamp ? 32'(OFF_CYC) :
                     (offCnt_q != 32'd0) ? offCnt_q - 32'd1 : 32'd0;
      retryCnt_q  <= enterRetry ? retryLoad :
                     (retryCnt_q != 32'd0) ? retryCnt_q - 32'd1 : 32'd0;
      // power-good seen wins over the clear when both land together
      preGood_q   <= preMatch ||
                     (preGood_q && !(state_q == ST_OFF && !enableOk));
    end
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loop_q         <= LOOP_RST;
      order_q        <= ORDER_RST;
      orderWritten_q <= 1'b0;
      group_q        <= GROUP_RST;
      oc_q           <= OC_RST;
      operation      <= OPER_RST;
      voutTarget     <= 16'h0000;
    end
    else
    begin
      if (wrLoop)
        loop_q <= cmdReq.wdata[24:0];
      if (wrOrder)
      begin
        order_q        <= cmdReq.wdata[15:0] & ORDER_MASK;
        orderWritten_q <= 1'b1;
      end
      if (wrGroup)
        group_q <= cmdReq.wdata[23:0] & GROUP_MASK;
      if (wrOc)
        oc_q <= {OC_FIXED, cmdReq.wdata[5:0]};
      if (wrOper)
        operation <= cmdReq.wdata[7:0];
      else if (obMatch)
        operation <= imbEvent.data[7:0];
      if (vbMatch)
        voutTarget <= imbEvent.data;
    end
  end

  // strap caught once after release; later writes take precedence
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_q      <= 16'h0000;
      strapTaken_q <= 1'b0;
    end
    else if (!strapTaken_q)
    begin
      strap_q      <= strapOrder & ORDER_MASK;
      strapTaken_q <= 1'b1;
    end
  end

  // status flag and command answers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      statusIout <= 8'h00;
      cmdRsp     <= '0;
      loopCfg    <= {7'h00, LOOP_RST};
    end
    else
    begin
      // a trip in the clearing cycle still leaves the flag set
      statusIout[OC_FLAG_BIT] <= ocTrip ||
        (statusIout[OC_FLAG_BIT] && !clearFaults);
      cmdRsp.valid <= cmdReq.valid;
      cmdRsp.err   <= (wrEn && !wrKnown) || (rdEn && !rdKnown);
      cmdRsp.data  <= rdEn ? rdData : 32'h00000000;
      loopCfg      <= wrLoop ? {7'h00, cmdReq.wdata[24:0]} : {7'h00, loop_q};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_pre_ready;
    $past(enableOk) && (!$past(orderEff[PRE_EN]) ||
      $past(preGood_q) || $past(preMatch));
  endsequence

  sequence s_retry_entry;
    state_q == ST_ON ##1 state_q == ST_RETRY;
  endsequence

  chk_loop_reset: assert property (
    $fell(rst) |-> loop_q == LOOP_RST && loopCfg == 32'h015a0100)
    else $error("loop tuning word not at reset value");

  chk_prequel_gate: assert property (
    ($rose(railOn) && $past(state_q) != ST_RETRY) |-> s_pre_ready)
    else $error("rail turned on before prequel power-good");

  chk_sequel_off: assert property (
    (state_q == ST_ON && seqMatch && biasS && !ocS && !pfFast)
      |=> state_q == ST_RAMP ##1 rampingDown)
    else $error("sequel power-down did not start turn-off");

  chk_order_rsvd: assert property (
    order_q[14:13] == 2'b00 && order_q[6:5] == 2'b00)
    else $error("reserved sequencing bits set");

  chk_order_reset: assert property (
    $fell(rst) |-> order_q == 16'h0000 && !orderWritten_q)
    else $error("sequencing word not zero after reset");

  chk_strap_override: assert property (
    wrOrder |=> orderEff == ($past(cmdReq.wdata[15:0]) & 16'h9f9f))
    else $error("written sequencing word not in effect");

  chk_vout_bcast: assert property (
    (evVb && !group_q[VB_EN]) |=> $stable(voutTarget))
    else $error("voltage broadcast taken while disabled");

  chk_oper_bcast: assert property (
    (obMatch && !wrOper) |=> operation == $past(imbEvent.data[7:0]))
    else $error("operation broadcast not applied");

  chk_pfail_fast: assert property (
    (state_q == ST_ON && pfFast)
      |=> (state_q == ST_HOLD || state_q == ST_OFF) && !railOn ##1 !railOn)
    else $error("immediate power-fail shutdown missed");

  chk_group_rsvd: assert property (
    group_q[23:22] == 2'b00 && group_q[15:14] == 2'b00 &&
    group_q[7:6] == 2'b00)
    else $error("reserved group bits set");

  chk_ident_read: assert property (
    (rdEn && cmdReq.code == CODE_IDENT)
      |=> cmdRsp.valid && !cmdRsp.err && cmdRsp.data[31:8] == 24'h0)
    else $error("identifier read answered wrongly");

  chk_oc_flag: assert property (
    ocTrip |=> statusIout[OC_FLAG_BIT] && oc_q[7:6] == 2'b10)
    else $error("overcurrent flag not set");

  chk_no_retry: assert property (
    (state_q == ST_FAULT && biasS && !clearFaults) |=> state_q == ST_FAULT)
    else $error("output left latched-off state without clear");

  chk_retry_load: assert property (
    s_retry_entry |-> retryCnt_q == retryLoad)
    else $error("retry wait not (delay+1) units");

  chk_retry_restart: assert property (
    (state_q == ST_RETRY && retryCnt_q == 32'd1 && biasS && enableOk &&
     !pfMatch) |=> state_q == ST_ON ##0 railOn)
    else $error("continuous retry did not restart");

  chk_oc_reset: assert property (
    $fell(rst) |-> oc_q == 8'h80)
    else $error("overcurrent response not 80h after reset");

  chk_pg_mismatch: assert property (
    (evPg && imbEvent.id != orderEff[PRE_ID_LO +: 5] && !preGood_q)
      |=> !preGood_q)
    else $error("mismatched power-good accepted");

endmodule : rail_sequencing_fault_config

// *** sim/peer_rail_model.sv ***
// peer rail model that puts events on the inter-module bus
`timescale 1ns/1ns
module peer_rail_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // event request from the bench
  input  wire logic                   sendGo,
  input  wire rail_seq_pkg::ev_kind_t sendKind,
  input  wire logic [4:0]             sendId,
  input  wire logic [15:0]            sendData,
  // bus event, one cycle wide
  output rail_seq_pkg::imb_event_t    imbEvent
);
  import rail_seq_pkg::*;
  // idle id and data flip each cycle, kind holds, so a stale id never looks valid
  always_ff @(posedge clk)
  begin
    if (rst)
      imbEvent <= '0;
    else if (sendGo)
      imbEvent <= '{1'b1, sendKind, sendId, sendData};
    else
      imbEvent <= '{1'b0, imbEvent.kind, ~imbEvent.id, ~imbEvent.data};
  end
endmodule : peer_rail_model

// *** sim/rail_sequencing_fault_config_tb.sv ***
// self-checking bench for the rail sequencing controller
`timescale 1ns/1ns
module rail_sequencing_fault_config_tb;
  import rail_seq_pkg::*;
  // short retry unit keeps the run small
  localparam int unsigned RETRY_SIM = 20;
  localparam int unsigned OFF_SIM   = 4;
  localparam int          LIMIT     = 20000;

  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  cmd_req_t    cmdReq      = '0;
  logic        clearFaults = 1'b0;
  logic        enablePin   = 1'b0;
  logic        ocFaultPin  = 1'b0;
  logic        biasOkPin   = 1'b1;
  logic [15:0] strapOrder  = 16'h8300;
  logic        sendGo      = 1'b0;
  ev_kind_t    sendKind    = EV_PGOOD;
  logic [4:0]  sendId      = '0;
  logic [15:0] sendData    = '0;
  cmd_rsp_t    cmdRsp;
  imb_event_t  imbEvent;
  logic        railOn;
  logic        rampingDown;
  logic [15:0] voutTarget;
  logic [7:0]  operation;
  logic [7:0]  statusIout;
  logic [31:0] loopCfg;
  logic [31:0] rdData;
  int          fails       = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  always #5 clk = ~clk;

  rail_sequencing_fault_config #(.RETRY_CYC(RETRY_SIM), .OFF_CYC(OFF_SIM))
    u_rail_sequencing_fault_config (.clk(clk), .rst(rst), .cmdReq(cmdReq),
    .clearFaults(clearFaults), .cmdRsp(cmdRsp), .imbEvent(imbEvent),
    .enablePin(enablePin), .ocFaultPin(ocFaultPin), .biasOkPin(biasOkPin),
    .strapOrder(strapOrder), .railOn(railOn), .rampingDown(rampingDown),
    .voutTarget(voutTarget), .operation(operation), .loopCfg(loopCfg),
    .statusIout(statusIout));

  peer_rail_model u_peer_rail_model (.clk(clk), .rst(rst), .sendGo(sendGo),
    .sendKind(sendKind), .sendId(sendId), .sendData(sendData),
    .imbEvent(imbEvent));

  task automatic give_verdict;
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one request, answer looked at in the cycle it stands
  task automatic cmd(input logic wr, input logic [7:0] code,
                     input logic [31:0] wd, input logic [3:0] idx,
                     input logic expErr);
    cmdReq = '{1'b1, wr, code, wd, idx};
    tick(1);
    cmdReq.valid = 1'b0;
    check({31'h0, cmdRsp.valid}, 32'h1);
    check({31'h0, cmdRsp.err}, {31'h0, expErr});
    rdData = cmdRsp.data;
    tick(1);
  endtask : cmd

  task automatic wr(input logic [7:0] code, input logic [31:0] wd);
    cmd(1'b1, code, wd, 4'h0, 1'b0);
  endtask : wr

  task automatic expect_reg(input logic [7:0] code, input logic [31:0] exp);
    cmd(1'b0, code, 32'h0, 4'h0, 1'b0);
    check(rdData, exp);
  endtask : expect_reg

  task automatic ev(input ev_kind_t k, input logic [4:0] id,
                    input logic [15:0] d);
    sendGo = 1'b1;
    sendKind = k;
    sendId = id;
    sendData = d;
    tick(1);
    sendGo = 1'b0;
    tick(2);
  endtask : ev

  task automatic waitRail(input logic want, input int maxCyc);
    int n;
    n = 0;
    while (railOn !== want && n < maxCyc)
    begin
      tick(1);
      n++;
    end
  endtask : waitRail

  task automatic railUp;
    enablePin = 1'b0;
    tick(8);
    enablePin = 1'b1;
    waitRail(1'b1, 10);
  endtask : railUp

  task automatic retryGap(output int n);
    n = 0;
    waitRail(1'b0, 10);
    while (railOn !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
  endtask : retryGap

  task automatic test_reset;
    expect_reg(CODE_LOOP_CFG, 32'h015a0100);
    check(loopCfg, 32'h015a0100);
    expect_reg(CODE_RAIL_ORDER, 32'h0);
    expect_reg(CODE_GROUP_CFG, 32'h0);
    expect_reg(CODE_OC_RESP, 32'h80);
  endtask : test_reset

  // strap holds prequel on rail 3 until the word is written
  task automatic test_strap;
    enablePin = 1'b1;
    tick(10);
    check({31'h0, railOn}, 32'h0);
    ev(EV_PGOOD, 5'd4, 16'h0);
    check({31'h0, railOn}, 32'h0);
    ev(EV_PGOOD, 5'd3, 16'h0);
    check({31'h0, railOn}, 32'h1);
    enablePin = 1'b0;
    tick(8);
    wr(CODE_RAIL_ORDER, 32'h0);
    enablePin = 1'b1;
    tick(8);
    check({31'h0, railOn}, 32'h1);
  endtask : test_strap

  task automatic test_masks;
    wr(CODE_RAIL_ORDER, 32'hffffffff);
    expect_reg(CODE_RAIL_ORDER, 32'h9f9f);
    wr(CODE_RAIL_ORDER, 32'h0);
    wr(CODE_GROUP_CFG, 32'hffffffff);
    expect_reg(CODE_GROUP_CFG, 32'h3f3f3f);
    wr(CODE_GROUP_CFG, 32'h0);
    wr(CODE_OC_RESP, 32'h0);
    expect_reg(CODE_OC_RESP, 32'h80);
    wr(CODE_OC_RESP, 32'h3f);
    expect_reg(CODE_OC_RESP, 32'hbf);
    wr(CODE_OC_RESP, 32'h80);
    wr(CODE_LOOP_CFG, 32'hffffffff);
    expect_reg(CODE_LOOP_CFG, 32'h01ffffff);
    check(loopCfg, 32'h01ffffff);
    wr(CODE_LOOP_CFG, 32'h015a0100);
    cmd(1'b0, 8'h55, 32'h0, 4'h0, 1'b1);
    cmd(1'b1, CODE_IDENT, 32'h1, 4'h0, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      cmd(1'b0, CODE_IDENT, 32'h0, i[3:0], 1'b0);
      check(rdData, {24'h0, IDENT_DEFAULT[127-8*i -: 8]});
    end
  endtask : test_masks

  task automatic test_sequel;
    wr(CODE_RAIL_ORDER, 32'h0085);
    ev(EV_PDOWN, 5'd6, 16'h0);
    check({31'h0, rampingDown}, 32'h0);
    ev(EV_PDOWN, 5'd5, 16'h0);
    check({31'h0, rampingDown}, 32'h1);
    tick(OFF_SIM - 2);
    check({31'h0, railOn}, 32'h1);
    waitRail(1'b0, 4);
    check({30'h0, railOn, rampingDown}, 32'h0);
    wr(CODE_RAIL_ORDER, 32'h0);
    railUp();
  endtask : test_sequel

  task automatic test_group;
    wr(CODE_GROUP_CFG, 32'h222124);
    ev(EV_VOUT, 5'd3, 16'h1234);
    check({16'h0, voutTarget}, 32'h0);
    ev(EV_VOUT, 5'd2, 16'h1234);
    check({16'h0, voutTarget}, 32'h1234);
    ev(EV_OPER, 5'd1, 16'h0000);
    check({24'h0, operation}, 32'h0);
    waitRail(1'b0, 8);
    check({31'h0, railOn}, 32'h0);
    ev(EV_OPER, 5'd1, 16'h0080);
    waitRail(1'b1, 4);
    check({31'h0, railOn}, 32'h1);
    ev(EV_PFAIL, 5'd5, 16'h0);
    check({31'h0, railOn}, 32'h1);
    ev(EV_PFAIL, 5'd4, 16'h0);
    check({30'h0, railOn, rampingDown}, 32'h0);
    wr(CODE_GROUP_CFG, 32'h020004);
    ev(EV_VOUT, 5'd2, 16'h5678);
    check({16'h0, voutTarget}, 32'h1234);
    ev(EV_OPER, 5'd1, 16'h0000);
    check({24'h0, operation}, 32'h80);
    railUp();
    ev(EV_PFAIL, 5'd4, 16'h0);
    check({31'h0, rampingDown}, 32'h1);
    waitRail(1'b0, 8);
    check({31'h0, railOn}, 32'h0);
    wr(CODE_GROUP_CFG, 32'h0);
    railUp();
  endtask : test_group

  // code 000 and an unused code both latch the rail off
  task automatic test_oc_latch;
    for (int c = 0; c < 2; c++)
    begin
      wr(CODE_OC_RESP, 32'h80 | (c << 3));
      ocFaultPin = 1'b1;
      tick(8);
      check({24'h0, statusIout}, 32'h80);
      expect_reg(CODE_STATUS_IOUT, 32'h80);
      ocFaultPin = 1'b0;
      tick(20);
      check({31'h0, railOn}, 32'h0);
      clearFaults = 1'b1;
      tick(1);
      clearFaults = 1'b0;
      waitRail(1'b1, 4);
      check({23'h0, statusIout, railOn}, 32'h1);
    end
  endtask : test_oc_latch

  task automatic test_oc_retry;
    int gap;
    wr(CODE_OC_RESP, 32'hb9);
    ocFaultPin = 1'b1;
    repeat (2)
    begin
      retryGap(gap);
      check(gap, 2 * RETRY_SIM);
    end
    // an off command ends the restart loop
    wr(CODE_OPERATION, 32'h0);
    waitRail(1'b1, 50);
    check({31'h0, railOn}, 32'h0);
    expect_reg(CODE_OPERATION, 32'h0);
    wr(CODE_OPERATION, 32'h80);
    biasOkPin = 1'b0;
    tick(6);
    waitRail(1'b1, 100);
    check({31'h0, railOn}, 32'h0);
    ocFaultPin = 1'b0;
    biasOkPin = 1'b1;
    clearFaults = 1'b1;
    tick(1);
    clearFaults = 1'b0;
    wr(CODE_OC_RESP, 32'h80);
    railUp();
    check({31'h0, railOn}, 32'h1);
  endtask : test_oc_retry

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    test_reset();
    test_strap();
    test_masks();
    test_sequel();
    test_group();
    test_oc_latch();
    test_oc_retry();
    give_verdict();
  end
endmodule : rail_sequencing_fault_config_tb
